// [rtl/cgl_line_ctrl.sv]
// four-line gpio control: sync, deglitch, debounce, invert, output source mux
// assumes an axi4-lite master on aclk and raw pins from another domain
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module cgl_line_ctrl
    import cgl_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write
    input  wire logic [AW-1:0]     s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DW-1:0]     s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [AW-1:0]     s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DW-1:0]          s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // connector lines
    input  wire logic [NLINES-1:0] pin_in,
    output logic [NLINES-1:0]      pin_out,
    output logic [NLINES-1:0]      pin_oe,
    output logic [NLINES-1:0]      aux_power_rail_enable,
    // internal sources
    input  wire logic [1:0]        counter_active,
    input  wire logic [1:0]        logic_block_out,
    input  wire logic              exposure_active,
    input  wire logic              trigger_ready,
    input  wire logic              pps_pulse,
    input  wire logic              serial_tx
);
    // configuration registers
    logic [1:0]        pick_r, upick_r;
    logic              fkind_r;
    logic [NLINES-1:0] dir_r, inv_r, aux_r, uo_r, out_r;
    logic [OW-1:0]     org_r [NLINES];
    logic [FW-1:0]     degw_r [NLINES];
    logic [FW-1:0]     debw_r [NLINES];
    // bus state
    logic              aw_full_r, w_full_r, bvalid_r, rvalid_r;
    logic [AW-1:0]     waddr_r;
    logic [DW-1:0]     wdata_r, rdata_r;
    logic [3:0]        wstrb_r;
    logic [1:0]        bresp_r, rresp_r;
    // line path
    logic [NLINES-1:0] s1_r, s2_r, s3_r, stab_r;
    logic [NLINES-1:0] dg_v, db_v, lvl;
    logic [6:0]        pre_r;
    logic              us_tick;

    // address decode shared by read and write
    function automatic logic mapped(input logic [AW-1:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= OFF_CTYPE);
    endfunction

    // read value of a register
    function automatic logic [DW-1:0] rd_word(input logic [AW-1:0] a);
        logic [DW-1:0] v;
        v = '0;
        case ({a[AW-1:2], 2'h0})
            OFF_PICK:  v[1:0] = pick_r;
            OFF_LCFG: begin
                v[B_DIR] = dir_r[pick_r];
                v[B_INV] = inv_r[pick_r];
                v[B_AUX] = aux_r[pick_r];
                v[B_ORG +: OW] = org_r[pick_r];
            end
            OFF_LEVEL: v[0] = lvl[pick_r];
            OFF_LVEC:  v[NLINES-1:0] = lvl;
            OFF_FKIND: v[0] = fkind_r;
            OFF_FDUR:  v[FW-1:0] = (fkind_r == FK_DEBOUNCE) ? debw_r[pick_r] : degw_r[pick_r];
            OFF_UPICK: v[1:0] = upick_r;
            OFF_UVAL:  v[0] = uo_r[upick_r];
            OFF_UVEC:  v[NLINES-1:0] = uo_r;
            OFF_CTYPE: v[1:0] = CTYPES[2*pick_r +: 2];
            default:   v = '0;
        endcase
        rd_word = v;
    endfunction

    // output source selection
    function automatic logic src_pick(input logic [OW-1:0] c, input logic [NLINES-1:0] l);
        logic s;
        s = 1'b0;
        case (c)
            ORG_LINE0, 5'h02, 5'h03, 5'h04: s = l[2'(c - ORG_LINE0)];
            ORG_USER0, 5'h06, 5'h07, 5'h08: s = uo_r[2'(c - ORG_USER0)];
            ORG_CNT0, 5'h0a: s = counter_active[1'(c - ORG_CNT0)];
            ORG_LB0, 5'h0c:  s = logic_block_out[1'(c - ORG_LB0)];
            ORG_EXPO: s = exposure_active;
            ORG_TRIG: s = trigger_ready;
            ORG_PPS:  s = pps_pulse;
            ORG_SER:  s = serial_tx;
            default:  s = 1'b0;
        endcase
        src_pick = s;
    endfunction

    // bus handshake and write merge
    wire           do_write = aw_full_r && w_full_r && !bvalid_r;
    wire [DW-1:0]  bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [DW-1:0]  wv = (rd_word(waddr_r) & ~bmask) | (wdata_r & bmask);
    wire [AW-1:0]  wa = {waddr_r[AW-1:2], 2'h0};
    wire           ar_go = s_axi_arvalid && s_axi_arready;
    assign s_axi_awready = !aw_full_r && !bvalid_r;
    assign s_axi_wready  = !w_full_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OK;
            waddr_r   <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                waddr_r   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= mapped(waddr_r) ? RESP_OK : RESP_ERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OK;
        end else if (ar_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word(s_axi_araddr);
            rresp_r  <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // configuration writes, per-line fields reached through the pick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pick_r  <= '0;
            upick_r <= '0;
            fkind_r <= FK_DEGLITCH;
            dir_r   <= '0;
            inv_r   <= '0;
            aux_r   <= '0;
            uo_r    <= '0;
            for (int k = 0; k < NLINES; k++) begin
                org_r[k]  <= ORG_OFF;
                degw_r[k] <= '0;
                debw_r[k] <= '0;
            end
        end else if (do_write) begin
            case (wa)
                OFF_PICK:  pick_r <= wv[1:0];
                OFF_LCFG: begin
                    dir_r[pick_r] <= wv[B_DIR];
                    inv_r[pick_r] <= wv[B_INV];
                    aux_r[pick_r] <= wv[B_AUX] & AUX_OK[pick_r];
                    org_r[pick_r] <= wv[B_ORG +: OW];
                end
                OFF_FKIND: fkind_r <= wv[0];
                OFF_FDUR: begin
                    if (fkind_r == FK_DEBOUNCE)
                        debw_r[pick_r] <= wv[FW-1:0];
                    else
                        degw_r[pick_r] <= wv[FW-1:0];
                end
                OFF_UPICK: upick_r <= wv[1:0];
                OFF_UVAL:  uo_r[upick_r] <= wv[0];
                OFF_UVEC:  uo_r <= wv[NLINES-1:0];
                default: ;
            endcase
        end
    end

    // pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            stab_r <= '0;
        end else begin
            s1_r   <= pin_in;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            stab_r <= (s2_r & ~(s2_r ^ s3_r)) | (stab_r & (s2_r ^ s3_r));
        end
    end

    // one pulse per microsecond
    assign us_tick = (pre_r == US_LAST);
    always_ff @(posedge aclk) begin
        if (!aresetn)
            pre_r <= '0;
        else
            pre_r <= us_tick ? 7'h00 : pre_r + 7'h01;
    end

    // per-line filters and output drive
    for (genvar i = 0; i < NLINES; i++) begin : gl
        logic          dg_r, db_r;
        logic [FW-1:0] dgc_r, hold_r;
        // deglitch: w+1 free-running ticks, or at once when w is 0, so a pulse of w us or less never passes
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                dg_r  <= 1'b0;
                dgc_r <= '0;
            end else if (stab_r[i] == dg_r) begin
                dgc_r <= '0;
            end else if (dgc_r > degw_r[i] || degw_r[i] == '0) begin
                dg_r  <= stab_r[i];
                dgc_r <= '0;
            end else if (us_tick) begin
                dgc_r <= dgc_r + 16'h0001;
            end
        end
        // debounce: first edge passes, then hold off for the width
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                db_r   <= 1'b0;
                hold_r <= '0;
            end else if (hold_r == '0) begin
                if (dg_r != db_r) begin
                    db_r   <= dg_r;
                    hold_r <= debw_r[i];
                end
            end else if (us_tick) begin
                hold_r <= hold_r - 16'h0001;
            end
        end
        // registered drive breaks loops between looped-back lines
        always_ff @(posedge aclk) begin
            if (!aresetn)
                out_r[i] <= 1'b0;
            else
                out_r[i] <= src_pick(org_r[i], lvl) ^ inv_r[i];
        end
        assign dg_v[i] = dg_r;
        assign db_v[i] = db_r;
        assign lvl[i]  = dir_r[i] ? out_r[i] : (db_r ^ inv_r[i]);
    end

    // pin drive
    assign pin_out = out_r & dir_r;
    assign pin_oe  = dir_r;
    assign aux_power_rail_enable = aux_r;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pick_write: assert property (do_write && wa == OFF_PICK |=> pick_r == $past(wv[1:0]))
        else $error("line pick not updated");
    a_oe_dir: assert property ($rose(dir_r[1]) |-> pin_oe[1] ##1 $stable(pin_oe[1]) || !dir_r[1])
        else $error("output enable does not follow direction");
    a_out_invert: assert property (dir_r[1] && org_r[1] == ORG_TRIG ##1 dir_r[1] |->
        pin_out[1] == ($past(trigger_ready) ^ $past(inv_r[1])))
        else $error("output level not source xor invert");
    a_level_read: assert property (ar_go && s_axi_araddr == OFF_LEVEL |=>
        s_axi_rvalid && s_axi_rdata[0] == $past(lvl[pick_r]) && s_axi_rdata[DW-1:1] == '0)
        else $error("pin level read mismatch");
    a_lvec_read: assert property (ar_go && s_axi_araddr == OFF_LVEC |=>
        s_axi_rdata[NLINES-1:0] == $past(lvl))
        else $error("level vector read mismatch");
    a_degl_wait: assert property ($changed(gl[3].dg_r) |-> $past(gl[3].dgc_r > degw_r[3] || degw_r[3] == '0))
        else $error("deglitch accepted early");
    a_deb_block: assert property ($changed(gl[3].db_r) |-> $past(gl[3].hold_r) == '0)
        else $error("debounce changed during hold");
    a_deb_chain: assert property ($changed(db_v[3]) |-> db_v[3] == $past(dg_v[3]))
        else $error("debounce not fed by deglitch");
    a_in_no_drive: assert property (!dir_r[3] |-> !pin_oe[3] && !pin_out[3])
        else $error("input line driven");
    a_uvec_write: assert property (do_write && wa == OFF_UVEC && wstrb_r[0] |=>
        uo_r == $past(wdata_r[NLINES-1:0]))
        else $error("soft output vector not written");
    a_aux_mask: assert property ((aux_r & ~AUX_OK) == '0)
        else $error("aux rail on unsupported line");
    a_reset_state: assert property (disable iff (1'b0) !aresetn |=> dir_r == '0 && uo_r == '0 && inv_r == '0)
        else $error("reset state wrong");

    c_write_resp: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
    c_degl_take:  cover property ($changed(gl[3].dg_r) && degw_r[3] != '0);
    c_deb_hold:   cover property (gl[1].hold_r != '0 && gl[1].dg_r != gl[1].db_r);
    c_loopback:   cover property (dir_r[2] && org_r[2] == ORG_LINE0 && $changed(pin_out[2]));
endmodule // cgl_line_ctrl

// [rtl/cgl_pkg.sv]
// constants, register map and field layout of the gpio line control block
// assumes a 125 MHz aclk and 32-bit axi4-lite register access
package cgl_pkg;
    localparam int          NLINES      = 4;
    localparam int          AW          = 8;
    localparam int          DW          = 32;
    localparam int          FW          = 16;           // filter width field, us
    // timing
    localparam int          CLK_PER_NS  = 8;
    localparam int          US_NS       = 1000;
    localparam int          US_CYC      = (US_NS + CLK_PER_NS - 1) / CLK_PER_NS;
    localparam logic [6:0]  US_LAST     = 7'(US_CYC - 1);
    // register byte offsets
    localparam logic [AW-1:0] OFF_PICK  = 8'h00;        // pin_index_pick
    localparam logic [AW-1:0] OFF_LCFG  = 8'h04;        // per-line config
    localparam logic [AW-1:0] OFF_LEVEL = 8'h08;        // pin_level, RO
    localparam logic [AW-1:0] OFF_LVEC  = 8'h0c;        // line_level_vector, RO
    localparam logic [AW-1:0] OFF_FKIND = 8'h10;        // filter_kind_pick
    localparam logic [AW-1:0] OFF_FDUR  = 8'h14;        // filter_duration
    localparam logic [AW-1:0] OFF_UPICK = 8'h18;        // soft_out_pick
    localparam logic [AW-1:0] OFF_UVAL  = 8'h1c;        // soft_out_level
    localparam logic [AW-1:0] OFF_UVEC  = 8'h20;        // soft_output_vector
    localparam logic [AW-1:0] OFF_CTYPE = 8'h24;        // circuit_type, RO
    // line config fields
    localparam int          B_DIR       = 0;
    localparam int          B_INV       = 1;
    localparam int          B_AUX       = 2;
    localparam int          B_ORG       = 8;
    localparam int          OW          = 5;            // output_origin width
    // filter kinds
    localparam logic        FK_DEGLITCH = 1'b0;
    localparam logic        FK_DEBOUNCE = 1'b1;
    // output_origin codes
    localparam logic [OW-1:0] ORG_OFF   = 5'h00;
    localparam logic [OW-1:0] ORG_LINE0 = 5'h01;        // 01..04 lines
    localparam logic [OW-1:0] ORG_USER0 = 5'h05;        // 05..08 soft outputs
    localparam logic [OW-1:0] ORG_CNT0  = 5'h09;        // 09..0a counters
    localparam logic [OW-1:0] ORG_LB0   = 5'h0b;        // 0b..0c logic blocks
    localparam logic [OW-1:0] ORG_EXPO  = 5'h0d;
    localparam logic [OW-1:0] ORG_TRIG  = 5'h0e;
    localparam logic [OW-1:0] ORG_PPS   = 5'h0f;
    localparam logic [OW-1:0] ORG_SER   = 5'h10;
    // circuit types
    typedef enum logic [1:0] {
        CGL_CT_TRISTATE = 2'h0,
        CGL_CT_OPTO     = 2'h1,
        CGL_CT_OPENDRN  = 2'h2
    } cgl_ctype_t;
    // per-line build options
    localparam logic [NLINES-1:0] AUX_OK = 4'h4;        // only line 2 has the rail
    localparam logic [7:0]  CTYPES      = {CGL_CT_TRISTATE, CGL_CT_TRISTATE, CGL_CT_OPTO, CGL_CT_OPTO};
    // bus responses
    localparam logic [1:0]  RESP_OK     = 2'h0;
    localparam logic [1:0]  RESP_ERR    = 2'h2;
endpackage

// [testbench/camera_gpio_line_control_tb.sv]
// self-checking bench for the gpio line control block
// assumes cgl_pkg, the design and the external circuit model are compiled first
`timescale 1ns/1ns
module camera_gpio_line_control_tb
    import cgl_pkg::*;
;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] wd;
        logic [31:0] rx;
        logic [1:0]  rs;
    } cgl_row_t;
    // register write, then read back: address, data, expected read, response
    localparam cgl_row_t ROWS [7] = '{
        '{OFF_PICK, 32'h2, 32'h2, RESP_OK}, '{OFF_LCFG, 32'hd06, 32'hd06, RESP_OK},
        '{OFF_PICK, 32'h0, 32'h0, RESP_OK}, '{OFF_LCFG, 32'h104, 32'h100, RESP_OK},
        '{OFF_CTYPE, 32'h2, 32'h1, RESP_OK}, '{OFF_UVEC, 32'hf5, 32'h5, RESP_OK},
        '{8'h28, 32'h1, 32'h0, RESP_ERR}};
    logic            aclk = 1'b0, aresetn = 1'b0;
    logic [AW-1:0]   awaddr = '0, araddr = '0;
    logic [DW-1:0]   wdata = '0, rdata, rd;
    logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic            awready, wready, bvalid, arready, rvalid;
    logic [1:0]      bresp, rresp, rs, cnt_act = 2'h0, lb_out = 2'h0;
    logic            expo = 1'b0, trig = 1'b0, pps = 1'b0, ser = 1'b0;
    logic [3:0]      ext_lvl = 4'h0, pin_in, pin_out, pin_oe, aux;
    logic [11:0]     src;
    logic [31:0]     exp_v;
    int              n_fail = 0, total_checks = 0;

    // 125 MHz clock
    always #4 aclk = ~aclk;

    cgl_line_ctrl u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .aux_power_rail_enable(aux),
        .counter_active(cnt_act), .logic_block_out(lb_out), .exposure_active(expo),
        .trigger_ready(trig), .pps_pulse(pps), .serial_tx(ser));

    cgl_ext_circuit u_ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        total_checks++;
        if (seen !== expv) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expv);
        end
    endtask

    // address and data offered together, bready held until the response
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (i == 100) begin n_fail++; report_and_stop(); end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (i == 100) begin n_fail++; report_and_stop(); end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // poll the level vector and compare line 3
    task automatic lvl3(input logic e);
        axi_rd(OFF_LVEC, rd, rs);
        chk(32'(rd[3]), 32'(e));
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        chk(32'({pin_oe, pin_out, aux}), 32'h0);
        aresetn <= 1'b1;
        axi_rd(OFF_LCFG, rd, rs); chk(rd, 32'h0);
        axi_rd(OFF_UVEC, rd, rs); chk(rd, 32'h0);
        // table of ordinary register cases
        for (int k = 0; k < 7; k++) begin
            axi_wr(ROWS[k].a, ROWS[k].wd, rs); chk(32'(rs), 32'(ROWS[k].rs));
            axi_rd(ROWS[k].a, rd, rs); chk(rd, ROWS[k].rx);
            chk(32'(rs), 32'(ROWS[k].rs));
        end
        chk(32'({pin_oe, aux}), 32'h4);
        axi_rd(OFF_LVEC, rd, rs); chk(rd, 32'h4);
        // source codes 05 to 11 on line 1, with two source patterns
        axi_wr(OFF_PICK, 32'h1, rs);
        for (int p = 0; p < 2; p++) begin
            {ser, pps, trig, expo, lb_out, cnt_act} <= (p == 1) ? 8'hb6 : 8'h49;
            src = {((p == 1) ? 8'hb6 : 8'h49), 4'h5};
            for (int c = 5; c < 18; c++) begin
                axi_wr(OFF_LCFG, 32'({5'(c), 8'h01}), rs);
                repeat (3) @(posedge aclk);
                exp_v = (c < 17) ? 32'(src[c-5]) : 32'h0;
                chk(32'(pin_out[1]), exp_v);
            end
        end
        chk(32'(pin_oe), 32'h2);
        axi_wr(OFF_LCFG, 32'h3, rs); repeat (3) @(posedge aclk);
        chk(32'(pin_out[1]), 32'h1);
        axi_rd(OFF_LEVEL, rd, rs); chk(rd, 32'h1);
        axi_rd(OFF_LVEC, rd, rs); chk(rd, 32'h6);
        // loop line 0 back out on line 1
        axi_wr(OFF_LCFG, 32'h101, rs);
        ext_lvl[0] <= 1'b1; repeat (20) @(posedge aclk); chk(32'(pin_out[1]), 32'h1);
        ext_lvl[0] <= 1'b0; repeat (20) @(posedge aclk); chk(32'(pin_out[1]), 32'h0);
        axi_wr(OFF_LCFG, 32'he00, rs); repeat (3) @(posedge aclk);
        chk(32'({pin_oe, pin_out}), 32'h0);
        // deglitch of 2 us on line 3: short pulse dropped, long one delayed
        axi_wr(OFF_PICK, 32'h3, rs); axi_wr(OFF_FKIND, 32'h0, rs); axi_wr(OFF_FDUR, 32'h2, rs);
        ext_lvl[3] <= 1'b1; repeat (100) @(posedge aclk);
        ext_lvl[3] <= 1'b0; repeat (300) @(posedge aclk); lvl3(1'b0);
        ext_lvl[3] <= 1'b1; repeat (220) @(posedge aclk); lvl3(1'b0);
        repeat (200) @(posedge aclk); lvl3(1'b1);
        // debounce of 3 us: first edge at once, a quick return held off
        axi_wr(OFF_FDUR, 32'h0, rs); axi_wr(OFF_FKIND, 32'h1, rs); axi_wr(OFF_FDUR, 32'h3, rs);
        ext_lvl[3] <= 1'b0; repeat (12) @(posedge aclk); lvl3(1'b0);
        ext_lvl[3] <= 1'b1; repeat (200) @(posedge aclk); lvl3(1'b0);
        repeat (300) @(posedge aclk); lvl3(1'b1);
        axi_rd(OFF_FDUR, rd, rs); chk(rd, 32'h3);
        axi_wr(OFF_PICK, 32'h0, rs); axi_rd(OFF_FDUR, rd, rs); chk(rd, 32'h0);
        // soft outputs by index
        axi_wr(OFF_UPICK, 32'h1, rs); axi_wr(OFF_UVAL, 32'h1, rs);
        axi_rd(OFF_UVEC, rd, rs); chk(rd, 32'h7);
        axi_wr(OFF_UPICK, 32'h0, rs); axi_wr(OFF_UVAL, 32'h0, rs);
        axi_rd(OFF_UVEC, rd, rs); chk(rd, 32'h6);
        axi_rd(OFF_UVAL, rd, rs); chk(rd, 32'h0);
        report_and_stop();
    end
endmodule // camera_gpio_line_control_tb

// [testbench/cgl_ext_circuit.sv]
// external circuits wired to the four connector lines
// assumes pin_out and pin_oe from the line control block, levels from the bench
`timescale 1ns/1ns
module cgl_ext_circuit
    import cgl_pkg::*;
(
    // line side of the block
    input  wire logic [NLINES-1:0] pin_out,
    input  wire logic [NLINES-1:0] pin_oe,
    // bench level for each external driver
    input  wire logic [NLINES-1:0] ext_lvl,
    // resolved wire level
    output logic [NLINES-1:0]      pin_in
);
    // the block's driver owns the wire while enabled, the outside circuit otherwise
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // cgl_ext_circuit
